/* File: src/dmd_pkg.sv */
package dmd_pkg;
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned IO_ADDR_W  = 6;
    localparam int unsigned DISP_W     = 6;
    localparam int unsigned REG_W      = 5;

    localparam logic [15:0] REG_SIZE   = 16'h0020;
    localparam logic [15:0] IO_SIZE    = 16'h0040;
    localparam logic [15:0] EXT_SIZE   = 16'h00a0;
    localparam logic [15:0] SRAM_SIZE  = 16'h1000;

    localparam logic [15:0] REG_BASE   = 16'h0000;
    localparam logic [15:0] IO_BASE    = REG_BASE + REG_SIZE;
    localparam logic [15:0] EXT_BASE   = IO_BASE + IO_SIZE;
    localparam logic [15:0] SRAM_BASE  = EXT_BASE + EXT_SIZE;
    localparam logic [15:0] SRAM_END   = SRAM_BASE + SRAM_SIZE;

    localparam int unsigned SRAM_AW    = 12;
    localparam int unsigned SRAM_CYC   = 2;

    localparam logic [4:0]  PTR_X_LO   = 5'h1a;
    localparam logic [4:0]  PTR_Y_LO   = 5'h1c;
    localparam logic [4:0]  PTR_Z_LO   = 5'h1e;

    typedef enum logic [4:0] {
        DMD_REG  = 5'b00001,
        DMD_IO   = 5'b00010,
        DMD_EXT  = 5'b00100,
        DMD_SRAM = 5'b01000,
        DMD_NONE = 5'b10000
    } dmd_region_e;

    typedef enum logic [2:0] {
        DMD_MODE_DIRECT = 3'h0,
        DMD_MODE_IND    = 3'h1,
        DMD_MODE_DISP   = 3'h2,
        DMD_MODE_PREDEC = 3'h3,
        DMD_MODE_POSTINC= 3'h4,
        DMD_MODE_IO     = 3'h5
    } dmd_mode_e;

    typedef enum logic [1:0] {
        DMD_PTR_X = 2'h0,
        DMD_PTR_Y = 2'h1,
        DMD_PTR_Z = 2'h2
    } dmd_ptr_e;

    typedef enum logic [2:0] {
        DMD_ST_IDLE = 3'b001,
        DMD_ST_REQ  = 3'b010,
        DMD_ST_DONE = 3'b100
    } dmd_state_e;

    function automatic dmd_region_e dmd_decode(input logic [15:0] addr);
        if (addr < IO_BASE) begin
            return DMD_REG;
        end else if (addr < EXT_BASE) begin
            return DMD_IO;
        end else if (addr < SRAM_BASE) begin
            return DMD_EXT;
        end else if (addr < SRAM_END) begin
            return DMD_SRAM;
        end else begin
            return DMD_NONE;
        end
    endfunction
endpackage

/* File: src/dmd_regfile.sv */
`timescale 1ns/100ps
`default_nettype none
// Working register file with a dedicated 16-bit pointer pair port.
module dmd_regfile
    import dmd_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [REG_W-1:0]  i_addr,
    input  wire logic              i_we,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic [REG_W-1:0]  i_ptr_lo,
    output logic      [ADDR_W-1:0] o_ptr,
    input  wire logic              i_ptr_we,
    input  wire logic [ADDR_W-1:0] i_ptr_wdata
);
    logic [DATA_W-1:0] regs_ff [2**REG_W];
    logic [REG_W-1:0]  ptr_hi;

    assign ptr_hi = i_ptr_lo | 5'h01;
    assign o_rdata = regs_ff[i_addr];
    assign o_ptr   = {regs_ff[ptr_hi], regs_ff[i_ptr_lo]};

    // Pointer write-back is applied after the data write so the pointer update wins a collision.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 2**REG_W; i++) begin
                regs_ff[i] <= 8'h00;
            end
        end else begin
            if (i_we) begin
                regs_ff[i_addr] <= i_wdata;
            end
            if (i_ptr_we) begin
                regs_ff[i_ptr_lo] <= i_ptr_wdata[7:0];
                regs_ff[ptr_hi]   <= i_ptr_wdata[15:8];
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/dmd_sram.sv */
`timescale 1ns/100ps
`default_nettype none
// Internal data array with a registered read port.
module dmd_sram
    import dmd_pkg::*;
(
    input  wire logic               i_ref_clk,
    input  wire logic [SRAM_AW-1:0] i_addr,
    input  wire logic               i_we,
    input  wire logic [DATA_W-1:0]  i_wdata,
    output logic      [DATA_W-1:0]  o_rdata
);
    logic [DATA_W-1:0] mem [2**SRAM_AW];

    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule
`default_nettype wire

/* File: src/dmd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Addresses below the SRAM go first to the 32 working registers, then 64 standard I/O, then 160 extended I/O.
// - The 4096 locations right after extended I/O are the internal data SRAM.
// - Extended I/O is reached only by the load and store groups, never by the short I/O instructions.
// - A short I/O instruction carries a 6-bit field that selects only among the 64 standard I/O locations.
// - Direct mode lets the instruction address reach any location of the data space.
// - Displacement mode adds an unsigned displacement of 0 to 63 to the Y or Z pointer.
// - The top six working registers form the X, Y and Z 16-bit pointer pairs.
// - Pre-decrement lowers the pointer, uses the new value as address and writes it back.
// - Post-increment uses the current pointer as address, then writes back the pointer plus one.
// - Every location in all four regions is reachable by each of the five data addressing modes.
// - Each internal SRAM access completes in exactly two clock cycles.
module dmd_decoder
    import dmd_pkg::*;
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_req,
    input  wire logic                 i_write,
    input  wire logic [2:0]           i_mode,
    input  wire logic [1:0]           i_ptr_sel,
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic [IO_ADDR_W-1:0] i_io_addr,
    input  wire logic [DISP_W-1:0]    i_disp,
    input  wire logic [DATA_W-1:0]    i_wdata,
    input  wire logic [REG_W-1:0]     i_rf_addr,
    input  wire logic                 i_rf_we,
    input  wire logic [DATA_W-1:0]    i_rf_wdata,
    output logic      [DATA_W-1:0]    o_rf_rdata,
    input  wire logic [DATA_W-1:0]    i_io_rdata,
    output logic                      o_busy,
    output logic                      o_done,
    output logic      [DATA_W-1:0]    o_rdata,
    output logic      [ADDR_W-1:0]    o_eff_addr,
    output logic      [4:0]           o_region,
    output logic                      o_io_sel,
    output logic                      o_io_we,
    output logic      [7:0]           o_io_offset,
    output logic      [DATA_W-1:0]    o_io_wdata,
    output logic                      o_fault
);
    dmd_state_e        state_ff;
    dmd_state_e        nxt_state;
    dmd_mode_e         mode;
    logic [REG_W-1:0]  ptr_lo;
    logic [ADDR_W-1:0] ptr_val;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] nxt_ptr;
    logic              ptr_upd;
    dmd_region_e       region;
    logic              take;
    logic              illegal;
    logic [REG_W-1:0]  rf_port_addr;
    logic              rf_port_we;
    logic [DATA_W-1:0] rf_port_wdata;
    logic [DATA_W-1:0] rf_rdata;
    logic [DATA_W-1:0] sram_rdata;
    logic [ADDR_W-1:0] addr_ff;
    dmd_region_e       region_ff;
    logic              write_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [ADDR_W-1:0] sram_off;

    assign mode = dmd_mode_e'(i_mode);
    assign take = i_req && (state_ff == DMD_ST_IDLE);

    always_comb begin
        case (dmd_ptr_e'(i_ptr_sel))
            DMD_PTR_Y: ptr_lo = PTR_Y_LO;
            DMD_PTR_Z: ptr_lo = PTR_Z_LO;
            default:   ptr_lo = PTR_X_LO;
        endcase
    end

    // Effective address and pointer write-back for each addressing mode.
    always_comb begin
        eff_addr = i_addr;
        nxt_ptr  = ptr_val;
        ptr_upd  = 1'b0;
        illegal  = 1'b0;
        case (mode)
            DMD_MODE_DIRECT: eff_addr = i_addr;
            DMD_MODE_IND: eff_addr = ptr_val;
            DMD_MODE_DISP: begin
                eff_addr = ptr_val + {{(ADDR_W-DISP_W){1'b0}}, i_disp};
                // Only Y and Z carry a displacement; X has no such form.
                illegal  = (dmd_ptr_e'(i_ptr_sel) == DMD_PTR_X);
            end
            DMD_MODE_PREDEC: begin
                nxt_ptr  = ptr_val - 16'h0001;
                eff_addr = nxt_ptr;
                ptr_upd  = 1'b1;
            end
            DMD_MODE_POSTINC: begin
                eff_addr = ptr_val;
                nxt_ptr  = ptr_val + 16'h0001;
                ptr_upd  = 1'b1;
            end
            DMD_MODE_IO: eff_addr = IO_BASE + {10'h000, i_io_addr};
            default: illegal = 1'b1;
        endcase
        if (i_ptr_sel == 2'h3) begin
            illegal = illegal || (mode != DMD_MODE_DIRECT && mode != DMD_MODE_IO);
        end
    end

    assign region = dmd_decode(eff_addr);

    always_comb begin
        case (state_ff)
            DMD_ST_IDLE: nxt_state = take ? DMD_ST_REQ : DMD_ST_IDLE;
            DMD_ST_REQ:  nxt_state = DMD_ST_DONE;
            DMD_ST_DONE: nxt_state = DMD_ST_IDLE;
            default:     nxt_state = DMD_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= DMD_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Every access spans two cycles, which is what the SRAM needs; other regions simply match it.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            addr_ff   <= 16'h0000;
            region_ff <= DMD_NONE;
            write_ff  <= 1'b0;
            wdata_ff  <= 8'h00;
        end else if (take) begin
            addr_ff   <= eff_addr;
            region_ff <= illegal ? DMD_NONE : region;
            write_ff  <= i_write;
            wdata_ff  <= i_wdata;
        end
    end

    // The array reads on the take edge from the live address, so its registered data is ready in the
    // second cycle; writes wait for the latched address in that second cycle.
    assign sram_off = (state_ff == DMD_ST_REQ) ? addr_ff - SRAM_BASE : eff_addr - SRAM_BASE;

    always_comb begin
        rf_port_addr  = i_rf_addr;
        rf_port_we    = i_rf_we;
        rf_port_wdata = i_rf_wdata;
        if (state_ff == DMD_ST_REQ && region_ff == DMD_REG) begin
            rf_port_addr  = addr_ff[REG_W-1:0];
            rf_port_we    = write_ff;
            rf_port_wdata = wdata_ff;
        end
    end

    dmd_regfile u_regfile (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_addr     (rf_port_addr),
        .i_we       (rf_port_we),
        .i_wdata    (rf_port_wdata),
        .o_rdata    (rf_rdata),
        .i_ptr_lo   (ptr_lo),
        .o_ptr      (ptr_val),
        .i_ptr_we   (take && ptr_upd && !illegal),
        .i_ptr_wdata(nxt_ptr)
    );

    dmd_sram u_sram (
        .i_ref_clk(i_ref_clk),
        .i_addr   (sram_off[SRAM_AW-1:0]),
        .i_we     (state_ff == DMD_ST_REQ && region_ff == DMD_SRAM && write_ff),
        .i_wdata  (wdata_ff),
        .o_rdata  (sram_rdata)
    );

    assign o_rf_rdata = rf_rdata;

    always_comb begin
        o_io_sel    = (state_ff == DMD_ST_REQ) && (region_ff == DMD_IO || region_ff == DMD_EXT);
        o_io_we     = o_io_sel && write_ff;
        o_io_offset = 8'(addr_ff - IO_BASE);
        o_io_wdata  = wdata_ff;
    end

    // Read data is captured in the second cycle so that o_done and o_rdata appear together.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (state_ff == DMD_ST_REQ && !write_ff) begin
            case (region_ff)
                DMD_REG:  o_rdata <= rf_rdata;
                DMD_IO:   o_rdata <= i_io_rdata;
                DMD_EXT:  o_rdata <= i_io_rdata;
                DMD_SRAM: o_rdata <= sram_rdata;
                default:  o_rdata <= 8'h00;
            endcase
        end
    end

    assign o_busy     = (state_ff != DMD_ST_IDLE);
    assign o_done     = (state_ff == DMD_ST_DONE);
    assign o_eff_addr = addr_ff;
    assign o_region   = region_ff;
    assign o_fault    = o_done && (region_ff == DMD_NONE);
endmodule
`default_nettype wire

/* File: tb/dmd_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module dmd_monitor
    import dmd_pkg::*;
(
    input wire logic                 i_ref_clk,
    input wire logic                 i_rst,
    input wire logic                 i_req,
    input wire logic [2:0]           i_mode,
    input wire logic [1:0]           i_ptr_sel,
    input wire logic [IO_ADDR_W-1:0] i_io_addr,
    input wire logic                 o_busy,
    input wire logic                 o_done,
    input wire logic [ADDR_W-1:0]    o_eff_addr,
    input wire logic [4:0]           o_region,
    input wire logic                 o_io_sel,
    input wire logic                 o_fault
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    logic take;
    assign take = i_req && !o_busy;
    logic bad_ff;
    // Remembers whether the taken request named a mode and pointer pair that the decoder must refuse.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bad_ff <= 1'b0;
        end else if (take) begin
            bad_ff <= (i_mode > 3'h5) || (i_mode == 3'h2 && i_ptr_sel == 2'h0)
                || (i_ptr_sel == 2'h3 && i_mode != 3'h0 && i_mode != 3'h5);
        end
    end
    property p_done_two;
        take |=> !o_done ##1 o_done ##1 !o_done;
    endproperty
    a_done_two: assert property (p_done_two) else $error("done not two cycles after take");
    property p_busy;
        take |=> o_busy [*2] ##1 !o_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy window wrong");
    property p_reg;
        o_done && !bad_ff && o_eff_addr < IO_BASE |-> o_region == DMD_REG && !o_fault;
    endproperty
    a_reg: assert property (p_reg) else $error("register region wrong");
    property p_io;
        o_done && !bad_ff && o_eff_addr >= IO_BASE && o_eff_addr < EXT_BASE |-> o_region == DMD_IO;
    endproperty
    a_io: assert property (p_io) else $error("standard io region wrong");
    property p_ext;
        o_done && !bad_ff && o_eff_addr >= EXT_BASE && o_eff_addr < SRAM_BASE |-> o_region == DMD_EXT;
    endproperty
    a_ext: assert property (p_ext) else $error("extended io region wrong");
    property p_sram;
        o_done && !bad_ff && o_eff_addr >= SRAM_BASE && o_eff_addr < SRAM_END |-> o_region == DMD_SRAM && !o_fault;
    endproperty
    a_sram: assert property (p_sram) else $error("sram region wrong");
    property p_none;
        o_done && o_eff_addr >= SRAM_END |-> o_fault && o_region == DMD_NONE;
    endproperty
    a_none: assert property (p_none) else $error("unmapped address not faulted");
    property p_illegal;
        o_done && bad_ff |-> o_fault && o_region == DMD_NONE;
    endproperty
    a_illegal: assert property (p_illegal) else $error("refused mode not faulted");
    property p_io_map;
        take && i_mode == 3'h5 |-> ##2 o_eff_addr == IO_BASE + {10'h000, $past(i_io_addr, 2)} && o_region == DMD_IO;
    endproperty
    a_io_map: assert property (p_io_map) else $error("short io address mapped wrong");
    property p_io_sel;
        take && i_mode == 3'h5 |=> o_io_sel;
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("short io select missing");
    c_postinc: cover property (take && i_mode == 3'h4);
    c_fault: cover property (o_done && o_fault);
    c_io: cover property (o_io_sel);
endmodule
bind dmd_decoder dmd_monitor u_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(i_req), .i_mode(i_mode),
    .i_ptr_sel(i_ptr_sel),
    .i_io_addr(i_io_addr), .o_busy(o_busy), .o_done(o_done), .o_eff_addr(o_eff_addr),
    .o_region(o_region), .o_io_sel(o_io_sel), .o_fault(o_fault));
`default_nettype wire

/* File: tb/dmd_io_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Peripheral side; unselected read data toggles so a stale value never passes.
module dmd_io_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_sel,
    input  wire logic       i_we,
    input  wire logic [7:0] i_off,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [256];
    logic [7:0] junk_ff = 8'h5a;
    always_ff @(posedge i_ref_clk) begin
        junk_ff <= ~junk_ff;
        if (i_sel && i_we) begin
            mem[i_off] <= i_wdata;
        end
    end
    assign o_rdata = i_sel ? mem[i_off] : junk_ff;
endmodule
`default_nettype wire

/* File: tb/data_memory_address_decoder_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module data_memory_address_decoder_tb_top;
    import dmd_pkg::*;
    localparam logic [15:0] TAB [10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060,
                                         16'h00ff, 16'h0100, 16'h10ff, 16'h1100, 16'hffff};
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_req = 1'b0;
    logic        i_write = 1'b0;
    logic [2:0]  i_mode = 3'h0;
    logic [1:0]  i_ptr_sel = 2'h0;
    logic [15:0] i_addr = 16'h0000;
    logic [5:0]  i_io_addr = 6'h00;
    logic [5:0]  i_disp = 6'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic [4:0]  i_rf_addr = 5'h00;
    logic        i_rf_we = 1'b0;
    logic [7:0]  i_rf_wdata = 8'h00;
    logic [7:0]  o_rf_rdata, i_io_rdata, o_rdata, o_io_wdata, o_io_offset, r_dat, d;
    logic        o_busy, o_done, o_io_sel, o_io_we, o_fault, r_flt;
    logic [15:0] o_eff_addr, r_eff, p, e;
    logic [4:0]  o_region, r_reg;
    int          err_count = 0;
    int          checks = 0;
    int          r_cyc = 0;
    logic [31:0] rng = 32'h0000f0c4;
    always #2 i_ref_clk = ~i_ref_clk;
    dmd_decoder uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(i_req), .i_write(i_write), .i_mode(i_mode),
        .i_ptr_sel(i_ptr_sel), .i_addr(i_addr), .i_io_addr(i_io_addr), .i_disp(i_disp), .i_wdata(i_wdata),
        .i_rf_addr(i_rf_addr), .i_rf_we(i_rf_we), .i_rf_wdata(i_rf_wdata), .o_rf_rdata(o_rf_rdata),
        .i_io_rdata(i_io_rdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_eff_addr(o_eff_addr),
        .o_region(o_region), .o_io_sel(o_io_sel), .o_io_we(o_io_we), .o_io_offset(o_io_offset),
        .o_io_wdata(o_io_wdata), .o_fault(o_fault));
    dmd_io_model u_io (.i_ref_clk(i_ref_clk), .i_sel(o_io_sel), .i_we(o_io_we), .i_off(o_io_offset),
        .i_wdata(o_io_wdata), .o_rdata(i_io_rdata));
    function automatic logic [15:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction
    function automatic logic [4:0] exp_reg(input logic [15:0] a);
        if (a < 16'h0020) return 5'h01;
        if (a < 16'h0060) return 5'h02;
        if (a < 16'h0100) return 5'h04;
        if (a < 16'h1100) return 5'h08;
        return 5'h10;
    endfunction
    function automatic logic [15:0] exp_ptr(input logic [2:0] m, input logic [15:0] v);
        return (m == 3'h3) ? v - 16'h0001 : (m == 3'h4) ? v + 16'h0001 : v;
    endfunction
    task automatic summarize();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic note(input logic ok, input logic [15:0] g, input logic [15:0] x);
        checks++;
        if (!ok) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk_addr(input logic [15:0] g, input logic [15:0] x);
        note(g === x, g, x);
    endtask
    task automatic chk_region(input logic [4:0] g, input logic [4:0] x);
        note(g === x, {11'h000, g}, {11'h000, x});
    endtask
    task automatic chk_data(input logic [7:0] g, input logic [7:0] x);
        note(g === x, {8'h00, g}, {8'h00, x});
    endtask
    task automatic chk_flag(input logic g, input logic x);
        note(g === x, {15'h0000, g}, {15'h0000, x});
    endtask
    // Holds the request one edge only; a second take must wait for busy to drop.
    task automatic acc(input logic [2:0] m, input logic [1:0] s, input logic [15:0] a,
                       input logic [5:0] f, input logic w, input logic [7:0] wd);
        int n;
        i_mode = m;
        i_ptr_sel = s;
        i_addr = a;
        i_io_addr = f;
        i_disp = f;
        i_write = w;
        i_wdata = wd;
        i_req = 1'b1;
        @(posedge i_ref_clk);
        #1 i_req = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 8) begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        if (o_done !== 1'b1) begin
            err_count++;
            summarize();
        end
        r_cyc = n;
        r_eff = o_eff_addr;
        r_reg = o_region;
        r_dat = o_rdata;
        r_flt = o_fault;
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic setp(input logic [4:0] a, input logic [15:0] v);
        i_rf_addr = a;
        i_rf_wdata = v[7:0];
        i_rf_we = 1'b1;
        @(posedge i_ref_clk);
        #1 i_rf_addr = a + 5'h01;
        i_rf_wdata = v[15:8];
        @(posedge i_ref_clk);
        #1 i_rf_we = 1'b0;
    endtask
    task automatic rdp(input logic [4:0] a, output logic [15:0] v);
        i_rf_addr = a + 5'h01;
        @(posedge i_ref_clk);
        #1 v[15:8] = o_rf_rdata;
        i_rf_addr = a;
        @(posedge i_ref_clk);
        #1 v[7:0] = o_rf_rdata;
    endtask
    initial begin
        logic [2:0] m;
        logic [1:0] s;
        logic [5:0] f;
        repeat (2) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            e = (i < 10) ? TAB[i] : rnd();
            acc(3'h0, 2'h3, e, 6'h00, 1'b0, 8'h00);
            chk_addr(r_eff, e);
            chk_region(r_reg, exp_reg(e));
            chk_flag(r_flt, e >= 16'h1100);
        end
        $display("test map done");
        for (int i = 0; i < 8; i++) begin
            e = rnd();
            f = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : e[5:0];
            d = e[15:8];
            acc(3'h5, 2'h3, 16'h0000, f, 1'b1, d);
            chk_addr(r_eff, 16'h0020 + {10'h000, f});
            acc(3'h5, 2'h3, 16'h0000, f, 1'b0, 8'h00);
            chk_data(r_dat, d);
            acc(3'h0, 2'h3, 16'h0020 + {10'h000, f}, 6'h00, 1'b0, 8'h00);
            chk_data(r_dat, d);
            acc(3'h0, 2'h3, {8'h00, 1'b1, e[6:0]}, 6'h00, 1'b1, ~d);
            acc(3'h0, 2'h3, {8'h00, 1'b1, e[6:0]}, 6'h00, 1'b0, 8'h00);
            chk_data(r_dat, ~d);
        end
        $display("test io done");
        for (int i = 0; i < 16; i++) begin
            m = 3'h1 + 3'(i % 4);
            s = (m == 3'h2) ? 2'(1 + i % 2) : 2'(i % 3);
            p = (i < 4) ? 16'h0000 : rnd() % 16'h1100;
            f = 6'(rnd());
            setp(5'h1a + {2'h0, s, 1'b0}, p);
            acc(m, s, 16'h0000, f, 1'b0, 8'h00);
            chk_addr(r_eff, (m == 3'h2) ? p + {10'h000, f} : (m == 3'h3) ? p - 16'h0001 : p);
            rdp(5'h1a + {2'h0, s, 1'b0}, e);
            chk_addr(e, exp_ptr(m, p));
        end
        acc(3'h2, 2'h0, 16'h0000, 6'h05, 1'b0, 8'h00);
        chk_flag(r_flt, 1'b1);
        d = 8'(rnd());
        acc(3'h0, 2'h3, 16'h0005, 6'h00, 1'b1, d);
        rdp(5'h04, e);
        chk_data(e[15:8], d);
        $display("test pointer done");
        for (int i = 0; i < 8; i++) begin
            e = (i == 0) ? 16'h0100 : (i == 1) ? 16'h10ff : 16'h0100 + rnd() % 16'h1000;
            d = 8'(rnd());
            acc(3'h0, 2'h3, e, 6'h00, 1'b1, d);
            setp(5'h1e, e);
            acc(3'h4, 2'h2, 16'h0000, 6'h00, 1'b0, 8'h00);
            chk_data(r_dat, d);
            chk_region(r_reg, exp_reg(e));
            chk_data(8'(r_cyc), 8'(SRAM_CYC - 1));
        end
        $display("test sram done");
        summarize();
    end
endmodule
`default_nettype wire
